// File: inc/flash_pkg.sv
// Notes on behaviour
// - 88h, 264 mode: 5 dummy, 10 page, 9 dummy.
// - 88h, 256 mode: 6 dummy, 10 page, 8 dummy.
// - 88h: chip select rise copies buffer, busy.
// - Failed byte program sets error flag; erase never sets it.
// - 82h address: dummy, page, buffer start bits.
// - Data bytes fill buffer from start, wrapping.
// - 82h: erase page to ones, then program buffer.
// - 02h, 264 mode: 1 to 264 data bytes.
// - 02h, 256 mode: 18-bit linear address, 1-256 bytes.
// - 02h programs only bytes actually clocked in.
// - Partial last byte aborts 02h, nothing programmed.
// - 02h duration is bytes times byte program time.
// - 81h address: dummy, page, dummy bits.
// - 81h: chip select rise erases page, busy.
package flash_pkg;
  localparam int          PAGES           = 1024;
  localparam int          STD_PAGE_BYTES  = 264;
  localparam int          BIN_PAGE_BYTES  = 256;
  localparam int          PAGE_W          = 10;
  localparam int          COL_W           = 9;
  localparam int          CNT_W           = 10;
  localparam int          STD_PAGE_LSB    = 9;
  localparam int          BIN_PAGE_LSB    = 8;
  localparam logic [7:0]  OP_PROG_BUF     = 8'h88;
  localparam logic [7:0]  OP_PROG_ERASE   = 8'h82;
  localparam logic [7:0]  OP_PROG_BYTES   = 8'h02;
  localparam logic [7:0]  OP_PAGE_ERASE   = 8'h81;
  localparam logic [2:0]  HDR_OPCODE      = 3'h0;
  localparam logic [2:0]  HDR_LAST_ADDR   = 3'h3;
  localparam logic [2:0]  HDR_DATA        = 3'h4;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          BYTE_PROGRAM_TIME_NS = 2000;
  localparam int          PAGE_ERASE_TIME_NS   = 100000;
  localparam int          TIMER_W         = 12;
  localparam int          BP_CYC_I = (BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     BYTE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
  localparam int          PE_CYC_I = (PAGE_ERASE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     PAGE_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [TIMER_W-1:0] BP_CYC = TIMER_W'(BP_CYC_I);
  localparam logic [TIMER_W-1:0] PE_CYC = TIMER_W'(PE_CYC_I);
  localparam logic [CNT_W-1:0]   STD_SIZE = CNT_W'(STD_PAGE_BYTES);
  localparam logic [CNT_W-1:0]   BIN_SIZE = CNT_W'(BIN_PAGE_BYTES);

  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [7:0]       data;
  } prog_word_t;

  typedef enum {ST_IDLE, ST_ERASE, ST_PROG} seq_state_t;
endpackage : flash_pkg

// File: logic/flash_prog_erase.sv
`timescale 1ns/1ps
module prog_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    out_valid_o = (cnt_q != '0);
    out_data_o  = mem_q[rd_q];
    push        = in_valid_i & in_ready_o;
    pop         = out_valid_o & out_ready_i;
    wr_d        = push ? AW'((32'(wr_q) + 1) % DEPTH) : wr_q;
    rd_d        = pop ? AW'((32'(rd_q) + 1) % DEPTH) : rd_q;
    cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule : prog_fifo

module flash_prog_erase (
  // System clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Serial link from the host
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  // Configuration
  input  wire logic page256_i,
  // Status
  output logic      busy_o,
  output logic      program_erase_error_flag_o
);
  import flash_pkg::*;

  // Link domain: byte assembly and buffer writes on the serial clock.
  logic [7:0]       buf_mem [STD_PAGE_BYTES];
  logic             armed_q;
  logic [1:0]       mode_sync_q, mode_sync_d;
  logic [2:0]       bit_q, bit_d, hdr_q, hdr_d;
  logic [6:0]       shift_q, shift_d;
  logic [7:0]       opcode_q, opcode_d, byte_in;
  logic [23:0]      addr_q, addr_d, addr_full;
  logic [CNT_W-1:0] nbytes_q, nbytes_d;
  logic [COL_W-1:0] bufptr_q, bufptr_d, start_q, start_d;
  logic             tog_q, tog_d, buf_we;
  logic [2:0]       bitc, hdrc;
  logic [CNT_W-1:0] nbc, lsize;

  // The clock stops between frames, so a new frame is recognised by this
  // flag, set while chip select is high and cleared by the first edge.
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b0;
    end
  end

  always_comb begin
    bitc        = armed_q ? 3'h0 : bit_q;
    hdrc        = armed_q ? HDR_OPCODE : hdr_q;
    nbc         = armed_q ? '0 : nbytes_q;
    lsize       = mode_sync_q[1] ? BIN_SIZE : STD_SIZE;
    byte_in     = {shift_q, si_i};
    addr_full   = {addr_q[15:0], byte_in};
    mode_sync_d = {mode_sync_q[0], page256_i};
    bit_d       = bitc + 3'h1;
    shift_d     = {shift_q[5:0], si_i};
    tog_d       = armed_q ? ~tog_q : tog_q;
    opcode_d    = opcode_q;
    addr_d      = addr_q;
    hdr_d       = hdrc;
    nbytes_d    = nbc;
    bufptr_d    = bufptr_q;
    start_d     = start_q;
    buf_we      = 1'b0;
    if (bitc == BIT_LAST) begin
      hdr_d = (hdrc == HDR_DATA) ? HDR_DATA : hdrc + 3'h1;
      if (hdrc == HDR_OPCODE) begin
        opcode_d = byte_in;
      end else if (hdrc != HDR_DATA) begin
        addr_d = addr_full;
        if (hdrc == HDR_LAST_ADDR) begin
          bufptr_d = mode_sync_q[1] ? {1'b0, addr_full[BIN_PAGE_LSB-1:0]}
                                    : addr_full[STD_PAGE_LSB-1:0];
          start_d  = bufptr_d;
        end
      end else if (opcode_q == OP_PROG_ERASE || opcode_q == OP_PROG_BYTES) begin
        buf_we   = 1'b1;
        bufptr_d = (CNT_W'(bufptr_q) + 10'h001 >= lsize) ? '0 : bufptr_q + 9'h001;
        nbytes_d = (nbc == '1) ? nbc : nbc + 10'h001;
      end
    end
  end

  // Mode is a static strap; the two-stage copy only guards metastability.
  always_ff @(posedge sck_i) begin
    mode_sync_q <= mode_sync_d;
    bit_q       <= bit_d;
    shift_q     <= shift_d;
    hdr_q       <= hdr_d;
    opcode_q    <= opcode_d;
    addr_q      <= addr_d;
    nbytes_q    <= nbytes_d;
    bufptr_q    <= bufptr_d;
    start_q     <= start_d;
    if (buf_we) begin
      buf_mem[bufptr_q] <= byte_in;
    end
  end

  // The frame toggle needs a known start for the core to compare against.
  // Reset is only released while the serial clock is stopped, so the
  // asynchronous clear cannot cut a frame.
  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end

  // Core domain: frame end detection and the self-timed sequencer.
  logic [7:0]       main_mem [PAGES][STD_PAGE_BYTES];
  logic [2:0]       cs_sync_q, cs_sync_d;
  logic [1:0]       tog_sync_q, tog_sync_d, mode_q, mode_d;
  logic             seen_q, seen_d;
  seq_state_t       st_q, st_d;
  logic             prog_after_q, prog_after_d, pend_q, pend_d, err_q, err_d;
  logic             busy_q, busy_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [COL_W-1:0] rdcol_q, rdcol_d;
  logic [CNT_W-1:0] left_q, left_d, csize, ncap;
  logic [TIMER_W-1:0] timer_q, timer_d;
  prog_word_t       pw_q, pw_d, push_word, pop_word;
  logic             push_valid, push_ready, pop_valid, pop_ready;
  logic             cs_rise, new_frame, erase_we, prog_we;
  logic [7:0]       merged;

  prog_fifo #(
    .WIDTH ($bits(prog_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_word),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_word)
  );

  // Frame fields are read two cycles after chip select rises, when the
  // serial clock has stopped and they are stable.
  always_comb begin
    cs_sync_d    = {cs_sync_q[1:0], cs_n_i};
    tog_sync_d   = {tog_sync_q[0], tog_q};
    mode_d       = {mode_q[0], page256_i};
    cs_rise      = cs_sync_q[1] & ~cs_sync_q[2];
    new_frame    = cs_rise & (tog_sync_q[1] != seen_q);
    csize        = mode_q[1] ? BIN_SIZE : STD_SIZE;
    ncap         = (nbytes_q > csize) ? csize : nbytes_q;
    seen_d       = cs_rise ? tog_sync_q[1] : seen_q;
    st_d         = st_q;
    page_d       = page_q;
    rdcol_d      = rdcol_q;
    left_d       = left_q;
    prog_after_d = prog_after_q;
    timer_d      = timer_q;
    pend_d       = pend_q;
    pw_d         = pw_q;
    err_d        = err_q;
    erase_we     = 1'b0;
    prog_we      = 1'b0;
    push_valid   = 1'b0;
    push_word    = '{col: rdcol_q, data: buf_mem[rdcol_q]};
    pop_ready    = 1'b0;
    merged       = main_mem[page_q][pw_q.col] & pw_q.data;
    case (st_q)
      ST_IDLE: begin
        if (new_frame && hdr_q == HDR_DATA) begin
          page_d  = mode_q[1] ? addr_q[BIN_PAGE_LSB +: PAGE_W]
                              : addr_q[STD_PAGE_LSB +: PAGE_W];
          rdcol_d = '0;
          left_d  = csize;
          timer_d = PE_CYC;
          case (opcode_q)
            OP_PAGE_ERASE: begin
              st_d         = ST_ERASE;
              prog_after_d = 1'b0;
              err_d        = 1'b0;
            end
            OP_PROG_ERASE: begin
              st_d         = ST_ERASE;
              prog_after_d = 1'b1;
              err_d        = 1'b0;
            end
            OP_PROG_BUF: begin
              st_d  = ST_PROG;
              err_d = 1'b0;
            end
            OP_PROG_BYTES: begin
              if (bit_q == 3'h0 && nbytes_q != '0) begin
                st_d    = ST_PROG;
                rdcol_d = start_q;
                left_d  = ncap;
                err_d   = 1'b0;
              end
            end
            default: begin
              st_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_ERASE: begin
        timer_d = timer_q - 12'h001;
        if (timer_q == 12'h001) begin
          erase_we = 1'b1;
          st_d     = prog_after_q ? ST_PROG : ST_IDLE;
        end
      end
      ST_PROG: begin
        push_valid = (left_q != '0);
        if (push_valid && push_ready) begin
          left_d  = left_q - 10'h001;
          rdcol_d = (CNT_W'(rdcol_q) + 10'h001 >= csize) ? '0 : rdcol_q + 9'h001;
        end
        pop_ready = ~pend_q;
        if (pend_q) begin
          timer_d = timer_q - 12'h001;
          if (timer_q == 12'h001) begin
            prog_we = 1'b1;
            pend_d  = 1'b0;
            if (merged != pw_q.data) begin
              err_d = 1'b1;
            end
          end
        end else if (pop_valid) begin
          pw_d    = pop_word;
          pend_d  = 1'b1;
          timer_d = BP_CYC;
        end else if (left_q == '0) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    busy_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_sync_q    <= 3'h7;
      tog_sync_q   <= 2'h0;
      mode_q       <= 2'h0;
      seen_q       <= 1'b0;
      st_q         <= ST_IDLE;
      page_q       <= '0;
      rdcol_q      <= '0;
      left_q       <= '0;
      prog_after_q <= 1'b0;
      timer_q      <= '0;
      pend_q       <= 1'b0;
      pw_q         <= '0;
      err_q        <= 1'b0;
      busy_q       <= 1'b0;
    end else begin
      cs_sync_q    <= cs_sync_d;
      tog_sync_q   <= tog_sync_d;
      mode_q       <= mode_d;
      seen_q       <= seen_d;
      st_q         <= st_d;
      page_q       <= page_d;
      rdcol_q      <= rdcol_d;
      left_q       <= left_d;
      prog_after_q <= prog_after_d;
      timer_q      <= timer_d;
      pend_q       <= pend_d;
      pw_q         <= pw_d;
      err_q        <= err_d;
      busy_q       <= busy_d;
    end
  end

  // Programming can only clear bits, which is why an unerased page shows up
  // as a mismatch on the error flag.
  always_ff @(posedge clk_i) begin
    if (erase_we) begin
      for (int i = 0; i < STD_PAGE_BYTES; i++) begin
        main_mem[page_q][i] <= 8'hFF;
      end
    end
    if (prog_we) begin
      main_mem[page_q][pw_q.col] <= merged;
    end
  end

  assign busy_o                     = busy_q;
  assign program_erase_error_flag_o = err_q;
endmodule : flash_prog_erase

// File: dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Serial link to the device
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  // Chip select rises just after time zero so the device sees a real edge.
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b0;
    si_o   = 1'b0;
    #1 cs_n_o = 1'b1;
  end

  // The link clock runs only inside a frame, so the idle line cannot leak stray bits.
  task automatic frame(input logic [7:0] b[$], input int cut);
    int n;
    n = b.size() * 8 - cut;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = b[i / 8][7 - i % 8];
      #3 sck_o = 1'b1;
      #3 sck_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask : frame
endmodule : spi_host_model

// File: dv/flash_prog_erase_props.sv
`timescale 1ns/1ps
module flash_prog_erase_props (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sck_i,
  // Link and configuration
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic page256_i,
  // Status
  input wire logic busy_o,
  input wire logic program_erase_error_flag_o
);
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  always_comb begin
    busy_cnt_d = busy_o ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_i) begin
    busy_cnt_q <= reset_i ? 16'h0000 : busy_cnt_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_reset_idle: assert property ($fell(reset_i) |-> !busy_o && !program_erase_error_flag_o)
    else $error("status not idle after reset");
  chk_start_after_frame: assert property ($rose(busy_o) |-> $past(cs_n_i, 2) && !$past(cs_n_i, 4))
    else $error("busy rose without a finished frame");
  chk_start_cs_high: assert property ($rose(busy_o) |-> cs_n_i)
    else $error("busy rose while selected");
  chk_busy_min_run: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("busy too short");
  chk_gap_after_done: assert property ($fell(busy_o) |-> !busy_o [*3])
    else $error("busy restarted without a frame");
  chk_err_while_busy: assert property ($rose(program_erase_error_flag_o) |-> busy_o || $past(busy_o))
    else $error("error flag set while idle");
  chk_err_clear_cmd: assert property ($fell(program_erase_error_flag_o) |-> ##[0:2] busy_o)
    else $error("error flag cleared without a command");
  chk_busy_bounded: assert property (busy_cnt_q <= 16'd13400)
    else $error("busy exceeds longest operation");
endmodule : flash_prog_erase_props

// File: dv/flash_prog_erase_tb_top.sv
`timescale 1ns/1ps
module flash_prog_erase_tb_top;
  import flash_pkg::*;
  logic       clk_i;
  logic       reset_i;
  logic       sck_i;
  logic       cs_n_i;
  logic       si_i;
  logic       page256_i;
  logic       busy_o;
  logic       program_erase_error_flag_o;
  int         miscompares;
  int         num_checks;
  logic [7:0] q[$];

  flash_prog_erase i_flash_prog_erase (.clk_i(clk_i), .reset_i(reset_i), .sck_i(sck_i),
    .cs_n_i(cs_n_i), .si_i(si_i), .page256_i(page256_i), .busy_o(busy_o),
    .program_erase_error_flag_o(program_erase_error_flag_o));
  spi_host_model i_spi_host_model (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  // Waiting for ready after every frame keeps the host inside its spacing.
  task automatic run(input logic [7:0] b[$], input int cut, output int len);
    int w;
    i_spi_host_model.frame(b, cut);
    len = 0;
    w = 0;
    while (busy_o !== 1'b1 && w < 8) begin
      @(negedge clk_i);
      w++;
    end
    while (busy_o === 1'b1 && len < 20000) begin
      @(negedge clk_i);
      len++;
    end
    repeat (5) @(negedge clk_i);
  endtask : run

  task automatic t_erase_program;
    int len;
    run({OP_PAGE_ERASE, 8'h00, 8'h06, 8'h00}, 0, len);
    check(len >= PE_CYC_I && len <= PE_CYC_I + 4, "erase length");
    run({OP_PROG_BYTES, 8'h00, 8'h07, 8'h06, 8'h55, 8'h0F}, 0, len);
    check(len >= 2 * BP_CYC_I && len <= 2 * BP_CYC_I + 6, "two byte length");
    run({OP_PROG_BYTES, 8'h00, 8'h06, 8'h00, 8'h00}, 0, len);
    check(program_erase_error_flag_o === 1'b0, "untouched byte");
    run({OP_PROG_BYTES, 8'h00, 8'h07, 8'h06, 8'hAA}, 0, len);
    check(program_erase_error_flag_o === 1'b1, "failed byte flag");
    run({OP_PROG_BYTES, 8'h00, 8'h07, 8'h00, 8'h00}, 3, len);
    check(len === 0, "partial byte not refused");
    $display("t_erase_program done");
  endtask : t_erase_program

  task automatic t_buffer_program;
    int len;
    q = {OP_PROG_ERASE, 8'h00, 8'h07, 8'h07};
    repeat (STD_PAGE_BYTES) q.push_back(8'hA5);
    run(q, 0, len);
    check(len >= PE_CYC_I + STD_PAGE_BYTES * BP_CYC_I, "erase program short");
    check(len <= PE_CYC_I + STD_PAGE_BYTES * (BP_CYC_I + 1) + 8, "erase program long");
    check(program_erase_error_flag_o === 1'b0, "flag not cleared");
    run({OP_PROG_BUF, 8'h00, 8'h06, 8'h00}, 0, len);
    check(len >= STD_PAGE_BYTES * BP_CYC_I, "page program short");
    check(len <= STD_PAGE_BYTES * (BP_CYC_I + 1) + 4, "page program long");
    check(program_erase_error_flag_o === 1'b0, "page program flag");
    $display("t_buffer_program done");
  endtask : t_buffer_program

  task automatic t_binary_mode;
    int len;
    page256_i = 1'b1;
    repeat (4) @(negedge clk_i);
    run({OP_PAGE_ERASE, 8'h00, 8'h07, 8'h00}, 0, len);
    check(len >= PE_CYC_I && len <= PE_CYC_I + 4, "binary erase length");
    run({OP_PROG_BYTES, 8'h00, 8'h07, 8'hFF, 8'h3C}, 0, len);
    check(program_erase_error_flag_o === 1'b0, "binary program flag");
    run({OP_PROG_BYTES, 8'h00, 8'h07, 8'hFF, 8'hC3}, 0, len);
    check(program_erase_error_flag_o === 1'b1, "binary overwrite flag");
    run({OP_PROG_BUF, 8'h00, 8'h07, 8'h00}, 0, len);
    check(len >= BIN_PAGE_BYTES * BP_CYC_I, "binary page short");
    check(len <= BIN_PAGE_BYTES * (BP_CYC_I + 1) + 4, "binary page long");
    check(program_erase_error_flag_o === 1'b1, "binary page flag");
    $display("t_binary_mode done");
  endtask : t_binary_mode

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    reset_i = 1'b0;
    page256_i = 1'b0;
    miscompares = 0;
    num_checks = 0;
    #1 reset_i = 1'b1;
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check(busy_o === 1'b0 && program_erase_error_flag_o === 1'b0, "reset state");
    t_erase_program();
    t_buffer_program();
    t_binary_mode();
    print_verdict();
  end

  // About twice the expected run time.
  initial begin
    #4000000;
    miscompares++;
    print_verdict();
  end
endmodule : flash_prog_erase_tb_top

bind flash_prog_erase flash_prog_erase_props i_flash_prog_erase_props (.clk_i(clk_i),
  .reset_i(reset_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .page256_i(page256_i),
  .busy_o(busy_o), .program_erase_error_flag_o(program_erase_error_flag_o));
